// file: core/sri_defs.vh
`ifndef SRI_DEFS_VH
`define SRI_DEFS_VH

// Register indices; byte address is four times the index
`define SRI_IDX_INDIRECT_DATA   8'h00
`define SRI_IDX_TIMER_COUNT     8'h01
`define SRI_IDX_PCL             8'h02
`define SRI_IDX_STATUS          8'h03
`define SRI_IDX_POINTER         8'h04
`define SRI_IDX_IO1_DATA        8'h05
`define SRI_IDX_IO2_DATA        8'h06
`define SRI_IDX_PC_UPPER        8'h0A
`define SRI_IDX_INT_CONTROL     8'h0B
`define SRI_IDX_PERIPH_FLAGS    8'h0C
`define SRI_IDX_COMPARATOR      8'h1F
`define SRI_IDX_PRESCALER       8'h81
`define SRI_IDX_IO1_DIR         8'h85
`define SRI_IDX_IO2_DIR         8'h86
`define SRI_IDX_PERIPH_ENABLES  8'h8C
`define SRI_IDX_POWER_CAUSE     8'h8E
`define SRI_IDX_EEPROM_INTF     8'h90
`define SRI_IDX_VREF            8'h9F
`define SRI_IDX_ACCUMULATOR     8'hA0
`define SRI_IDX_CAUSE_STATE     8'hA1

// Reset and wake values
`define SRI_STATUS_POR          8'h18
`define SRI_PRESCALER_RST       8'hFF
`define SRI_IO1_DIR_RST         5'h1F
`define SRI_IO2_DIR_RST         8'hFF
`define SRI_EEPROM_FORCE        8'h07
`define SRI_VREF_MASK           8'hEF
`define SRI_IRQ_VECTOR          13'h0004

// Field positions
`define SRI_STATUS_TO           4
`define SRI_STATUS_PD           3
`define SRI_GIE_BIT             7
`define SRI_POWER_CAUSE_POR_BIT        1
`define SRI_POWER_CAUSE_BO_BIT         0
`define SRI_PERIPH_BIT          0

// Recorded reset causes
`define SRI_CAUSE_NONE          3'h0
`define SRI_CAUSE_EXT           3'h1
`define SRI_CAUSE_EXT_SLEEP     3'h2
`define SRI_CAUSE_WDT           3'h3
`define SRI_CAUSE_BROWNOUT      3'h4
`define SRI_CAUSE_POR           3'h5
`define SRI_CAUSE_WAKE_WDT      3'h6
`define SRI_CAUSE_WAKE_IRQ      3'h7

// Synchronised input vector layout
`define SRI_IN_POR              0
`define SRI_IN_BROWNOUT         1
`define SRI_IN_WATCHDOG         2
`define SRI_IN_EXT_PIN          3
`define SRI_IN_WAKE_IRQ         4
`define SRI_IN_WAKE_WDT         5
`define SRI_IN_WIDTH            6

`endif

// file: core/sri_sync.v
`timescale 1ns/100ps
`include "sri_defs.vh"

// Three-stage synchroniser; a bit changes once stages two and three agree
module sri_sync
(
	input  wire                      clk,
	input  wire                      rst_n,
	input  wire [`SRI_IN_WIDTH-1:0]  async_in,
	output wire [`SRI_IN_WIDTH-1:0]  sync_out
);

	reg [`SRI_IN_WIDTH-1:0] stage1;
	reg [`SRI_IN_WIDTH-1:0] stage2;
	reg [`SRI_IN_WIDTH-1:0] stage3;

	// Shift chain
	always @(posedge clk)
	begin
		if (!rst_n)
		begin
			stage1 <= {`SRI_IN_WIDTH{1'b0}};
			stage2 <= {`SRI_IN_WIDTH{1'b0}};
			stage3 <= {`SRI_IN_WIDTH{1'b0}};
		end
		else
		begin
			stage1 <= async_in;
			stage2 <= stage1;
			stage3 <= stage2;
		end
	end

	// Agreement filter per bit
	genvar i;
	generate
		for (i = 0; i < `SRI_IN_WIDTH; i = i + 1)
		begin : g_bit
			reg level;
			always @(posedge clk)
			begin
				if (!rst_n)
					level <= 1'b0;
				else if (stage2[i] == stage3[i])
					level <= stage3[i];
			end
			assign sync_out[i] = level;
		end
	endgenerate

endmodule

// file: core/sri_sfr_init.v
// Summary of operation
// - Timer, pointer and port data undefined at power-on, else preserved.
// - Low PC byte clears on every reset; wake continues at PC plus one.
// - Status 0001 1xxx at power-on; cause bits set on resets and wakes.
// - Comparator control six bits clear on resets, kept on wake.
// - Upper PC latch five bits clear on resets, kept on wake.
// - Interrupt control clears bits 7..1 on resets; wake keeps plus wake flags.
// - Prescaler and edge configuration all ones on resets, kept on wake.
// - Both direction registers all ones on resets, kept on wake.
// - EEPROM interface low three bits forced to one on every reset and wake.
// - Voltage reference clears seven bits on resets, kept on wake; bit 4 absent.
// - Unimplemented register bits always read as zero.
// - Interrupt wake with global enable set loads the interrupt vector.
// - Interrupt wake sets the matching request flags.
// - Power-on flag clears on power-on reset only; software sets it.
// - Brown-out flag clears on a brown-out reset.
//
// Decided for this implementation: the APB register port.
`timescale 1ns/100ps
`include "sri_defs.vh"

module sri_sfr_init
(
	input  wire        clk,
	input  wire        rst_n,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [9:0]  paddr,
	input  wire [31:0] pwdata,
	output wire        pready,
	output reg  [31:0] prdata,
	output reg         pslverr,
	input  wire        por_req,
	input  wire        brownout_req,
	input  wire        watchdog_req,
	input  wire        external_reset_pin_req,
	input  wire        wake_irq_req,
	input  wire        wake_watchdog_req,
	input  wire        sleep_active,
	input  wire [7:0]  wake_int_flags,
	input  wire        wake_periph_flag,
	input  wire [12:0] pc_current,
	output reg         core_hold,
	output reg         pc_load,
	output reg  [12:0] pc_load_value,
	output reg         global_irq_enable,
	output reg  [7:0]  prescaler_edge_config_out,
	output reg  [4:0]  first_io_direction_out,
	output reg  [7:0]  second_io_direction_out
);

	localparam ST_RUN  = 1'b0;
	localparam ST_HOLD = 1'b1;

	reg  [7:0]              working_accumulator;
	reg  [7:0]              timer_count;
	reg  [7:0]              program_counter_low;
	reg  [7:0]              core_status;
	reg  [7:0]              indirect_pointer;
	reg  [4:0]              first_io_data;
	reg  [7:0]              second_io_data;
	reg  [4:0]              program_counter_upper_latch;
	reg  [7:0]              interrupt_control;
	reg                     periph_flag;
	reg  [5:0]              comparator_control;
	reg  [7:0]              prescaler_edge_config;
	reg  [4:0]              first_io_direction;
	reg  [7:0]              second_io_direction;
	reg                     periph_enable;
	reg  [1:0]              power_cause;
	reg  [7:0]              eeprom_serial_interface;
	reg  [7:0]              vref_control;
	reg                     state;
	reg  [2:0]              cause;
	reg  [2:0]              next_cause;
	reg                     held_in_sleep;
	reg                     wake_irq_d;
	reg                     wake_wdt_d;
	wire [`SRI_IN_WIDTH-1:0] raw_in;
	wire [`SRI_IN_WIDTH-1:0] sync_in;
	wire                    any_reset;
	wire                    release_now;
	wire                    wake_irq_evt;
	wire                    wake_wdt_evt;
	wire                    wake_evt;
	wire                    vector_load;
	wire [12:0]             next_pc;
	wire [7:0]              reg_index;
	wire                    addr_ok;
	wire                    setup_phase;
	wire                    write_en;
	reg  [7:0]              read_value;
	reg                     read_hit;

	assign raw_in = {wake_watchdog_req, wake_irq_req, external_reset_pin_req,
		watchdog_req, brownout_req, por_req};

	// Cause inputs come from the reset logic, outside this clock
	sri_sync u_sync
	(
		.clk      (clk),
		.rst_n    (rst_n),
		.async_in (raw_in),
		.sync_out (sync_in)
	);

	assign any_reset    = sync_in[`SRI_IN_POR] | sync_in[`SRI_IN_BROWNOUT] |
		sync_in[`SRI_IN_WATCHDOG] | sync_in[`SRI_IN_EXT_PIN];
	assign release_now  = (state == ST_HOLD) && !any_reset;
	assign wake_irq_evt = (state == ST_RUN) && !any_reset && sync_in[`SRI_IN_WAKE_IRQ] && !wake_irq_d;
	assign wake_wdt_evt = (state == ST_RUN) && !any_reset && !wake_irq_evt &&
		sync_in[`SRI_IN_WAKE_WDT] && !wake_wdt_d;
	assign wake_evt     = wake_irq_evt | wake_wdt_evt;
	assign vector_load  = wake_irq_evt && interrupt_control[`SRI_GIE_BIT];
	assign next_pc      = vector_load ? `SRI_IRQ_VECTOR : pc_current + 13'h0001;

	// Strongest cause seen during the hold, power-on first
	always @*
	begin
		next_cause = cause;
		if (sync_in[`SRI_IN_POR])
			next_cause = `SRI_CAUSE_POR;
		else if (sync_in[`SRI_IN_BROWNOUT] && cause != `SRI_CAUSE_POR)
			next_cause = `SRI_CAUSE_BROWNOUT;
		else if (sync_in[`SRI_IN_WATCHDOG] && cause < `SRI_CAUSE_WDT)
			next_cause = `SRI_CAUSE_WDT;
		else if (sync_in[`SRI_IN_EXT_PIN] && cause == `SRI_CAUSE_NONE)
			next_cause = held_in_sleep ? `SRI_CAUSE_EXT_SLEEP : `SRI_CAUSE_EXT;
	end

	// Hold state and cause recording
	always @(posedge clk)
	begin
		if (!rst_n)
		begin
			state         <= ST_HOLD;
			cause         <= `SRI_CAUSE_POR;
			held_in_sleep <= 1'b0;
			wake_irq_d    <= 1'b0;
			wake_wdt_d    <= 1'b0;
			core_hold     <= 1'b1;
			pc_load       <= 1'b0;
			pc_load_value <= 13'h0000;
		end
		else
		begin
			wake_irq_d <= sync_in[`SRI_IN_WAKE_IRQ];
			wake_wdt_d <= sync_in[`SRI_IN_WAKE_WDT];
			pc_load    <= release_now | wake_evt;
			if (release_now)
				pc_load_value <= 13'h0000;
			else if (wake_evt)
				pc_load_value <= next_pc;
			case (state)
				ST_RUN:
				begin
					if (any_reset)
					begin
						state         <= ST_HOLD;
						core_hold     <= 1'b1;
						held_in_sleep <= sleep_active;
						cause         <= `SRI_CAUSE_NONE;
					end
					else if (wake_irq_evt)
						cause <= `SRI_CAUSE_WAKE_IRQ;
					else if (wake_wdt_evt)
						cause <= `SRI_CAUSE_WAKE_WDT;
				end
				ST_HOLD:
				begin
					cause <= next_cause;
					if (!any_reset)
					begin
						state     <= ST_RUN;
						core_hold <= 1'b0;
					end
				end
				default:
				begin
					state     <= ST_HOLD;
					core_hold <= 1'b1;
				end
			endcase
		end
	end

	// APB decode; answer comes in the access phase, no wait states
	assign reg_index   = paddr[9:2];
	assign addr_ok     = (paddr[1:0] == 2'b00);
	assign setup_phase = psel && !penable;
	assign pready      = psel && penable;
	assign write_en    = psel && penable && pwrite && addr_ok && read_hit && !core_hold;

	// Read mux; absent bits read zero
	always @*
	begin
		read_hit   = 1'b1;
		read_value = 8'h00;
		case (reg_index)
			`SRI_IDX_INDIRECT_DATA:  read_value = 8'h00;
			`SRI_IDX_TIMER_COUNT:    read_value = timer_count;
			`SRI_IDX_PCL:            read_value = program_counter_low;
			`SRI_IDX_STATUS:         read_value = core_status;
			`SRI_IDX_POINTER:        read_value = indirect_pointer;
			`SRI_IDX_IO1_DATA:       read_value = {3'b000, first_io_data};
			`SRI_IDX_IO2_DATA:       read_value = second_io_data;
			`SRI_IDX_PC_UPPER:       read_value = {3'b000, program_counter_upper_latch};
			`SRI_IDX_INT_CONTROL:    read_value = interrupt_control;
			`SRI_IDX_PERIPH_FLAGS:   read_value = {7'h00, periph_flag};
			`SRI_IDX_COMPARATOR:     read_value = {2'b00, comparator_control};
			`SRI_IDX_PRESCALER:      read_value = prescaler_edge_config;
			`SRI_IDX_IO1_DIR:        read_value = {3'b000, first_io_direction};
			`SRI_IDX_IO2_DIR:        read_value = second_io_direction;
			`SRI_IDX_PERIPH_ENABLES: read_value = {7'h00, periph_enable};
			`SRI_IDX_POWER_CAUSE:    read_value = {6'h00, power_cause};
			`SRI_IDX_EEPROM_INTF:    read_value = eeprom_serial_interface;
			`SRI_IDX_VREF:           read_value = vref_control & `SRI_VREF_MASK;
			`SRI_IDX_ACCUMULATOR:    read_value = working_accumulator;
			`SRI_IDX_CAUSE_STATE:    read_value = {3'b000, held_in_sleep, core_hold, cause};
			default:
			begin
				read_hit   = 1'b0;
				read_value = 8'h00;
			end
		endcase
	end

	// Read data and error captured in the setup cycle
	always @(posedge clk)
	begin
		if (!rst_n)
		begin
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end
		else if (setup_phase)
		begin
			prdata  <= (read_hit && addr_ok) ? {24'h000000, read_value} : 32'h0000_0000;
			pslverr <= !(read_hit && addr_ok);
		end
	end

	// Core data registers: undefined at power-on, kept otherwise
	always @(posedge clk)
	begin
		if (!rst_n)
		begin
			working_accumulator <= 8'h00;
			timer_count         <= 8'h00;
			indirect_pointer    <= 8'h00;
			first_io_data       <= 5'h00;
			second_io_data      <= 8'h00;
		end
		else if (write_en)
		begin
			case (reg_index)
				`SRI_IDX_ACCUMULATOR: working_accumulator <= pwdata[7:0];
				`SRI_IDX_TIMER_COUNT: timer_count <= pwdata[7:0];
				`SRI_IDX_POINTER:     indirect_pointer <= pwdata[7:0];
				`SRI_IDX_IO1_DATA:    first_io_data <= pwdata[4:0];
				`SRI_IDX_IO2_DATA:    second_io_data <= pwdata[7:0];
				default:              working_accumulator <= working_accumulator;
			endcase
		end
	end

	// Reset-valued registers, loaded on the release cycle or on wake
	always @(posedge clk)
	begin
		if (!rst_n)
		begin
			program_counter_low         <= 8'h00;
			core_status                 <= `SRI_STATUS_POR;
			program_counter_upper_latch <= 5'h00;
			interrupt_control           <= 8'h00;
			periph_flag                 <= 1'b0;
			comparator_control          <= 6'h00;
			prescaler_edge_config       <= `SRI_PRESCALER_RST;
			first_io_direction          <= `SRI_IO1_DIR_RST;
			second_io_direction         <= `SRI_IO2_DIR_RST;
			periph_enable               <= 1'b0;
			power_cause                 <= 2'b00;
			eeprom_serial_interface     <= `SRI_EEPROM_FORCE;
			vref_control                <= 8'h00;
		end
		else if (release_now)
		begin
			program_counter_low         <= 8'h00;
			program_counter_upper_latch <= 5'h00;
			interrupt_control[7:1]      <= 7'h00;
			periph_flag                 <= 1'b0;
			periph_enable               <= 1'b0;
			comparator_control          <= 6'h00;
			prescaler_edge_config       <= `SRI_PRESCALER_RST;
			first_io_direction          <= `SRI_IO1_DIR_RST;
			second_io_direction         <= `SRI_IO2_DIR_RST;
			eeprom_serial_interface     <= eeprom_serial_interface | `SRI_EEPROM_FORCE;
			vref_control                <= 8'h00;
			case (next_cause)
				`SRI_CAUSE_POR:
				begin
					core_status <= {3'b000, 2'b11, core_status[2:0]};
					power_cause <= 2'b00;
				end
				`SRI_CAUSE_BROWNOUT:
				begin
					core_status <= {3'b000, 2'b11, core_status[2:0]};
					power_cause[`SRI_POWER_CAUSE_BO_BIT] <= 1'b0;
				end
				`SRI_CAUSE_WDT:
					core_status <= {3'b000, 2'b01, core_status[2:0]};
				`SRI_CAUSE_EXT_SLEEP:
					core_status <= {3'b000, 2'b10, core_status[2:0]};
				default:
					core_status <= {3'b000, core_status[4:0]};
			endcase
		end
		else if (wake_evt)
		begin
			program_counter_low     <= next_pc[7:0];
			core_status[`SRI_STATUS_TO] <= wake_irq_evt;
			core_status[`SRI_STATUS_PD] <= 1'b0;
			eeprom_serial_interface <= eeprom_serial_interface | `SRI_EEPROM_FORCE;
			if (wake_irq_evt)
			begin
				interrupt_control <= interrupt_control | wake_int_flags;
				periph_flag       <= periph_flag | wake_periph_flag;
			end
		end
		else if (write_en)
		begin
			case (reg_index)
				`SRI_IDX_PCL:            program_counter_low <= pwdata[7:0];
				`SRI_IDX_STATUS:         core_status <= {pwdata[7:5], core_status[4:3], pwdata[2:0]};
				`SRI_IDX_PC_UPPER:       program_counter_upper_latch <= pwdata[4:0];
				`SRI_IDX_INT_CONTROL:    interrupt_control <= pwdata[7:0];
				`SRI_IDX_PERIPH_FLAGS:   periph_flag <= pwdata[`SRI_PERIPH_BIT];
				`SRI_IDX_COMPARATOR:     comparator_control <= pwdata[5:0];
				`SRI_IDX_PRESCALER:      prescaler_edge_config <= pwdata[7:0];
				`SRI_IDX_IO1_DIR:        first_io_direction <= pwdata[4:0];
				`SRI_IDX_IO2_DIR:        second_io_direction <= pwdata[7:0];
				`SRI_IDX_PERIPH_ENABLES: periph_enable <= pwdata[`SRI_PERIPH_BIT];
				`SRI_IDX_POWER_CAUSE:    power_cause <= pwdata[1:0];
				`SRI_IDX_EEPROM_INTF:    eeprom_serial_interface <= pwdata[7:0];
				`SRI_IDX_VREF:           vref_control <= pwdata[7:0] & `SRI_VREF_MASK;
				default:                 power_cause <= power_cause;
			endcase
		end
	end

	// Registered copies for the core and pins
	always @(posedge clk)
	begin
		if (!rst_n)
		begin
			global_irq_enable         <= 1'b0;
			prescaler_edge_config_out <= `SRI_PRESCALER_RST;
			first_io_direction_out    <= `SRI_IO1_DIR_RST;
			second_io_direction_out   <= `SRI_IO2_DIR_RST;
		end
		else
		begin
			global_irq_enable         <= interrupt_control[`SRI_GIE_BIT];
			prescaler_edge_config_out <= prescaler_edge_config;
			first_io_direction_out    <= first_io_direction;
			second_io_direction_out   <= second_io_direction;
		end
	end

endmodule

// file: tb/sri_sfr_init_sva.sv
`timescale 1ns/100ps
module sri_chk
(
	input wire        clk,
	input wire        rst_n,
	input wire        pready,
	input wire [31:0] prdata,
	input wire        por_req,
	input wire        brownout_req,
	input wire        watchdog_req,
	input wire        external_reset_pin_req,
	input wire        core_hold,
	input wire        pc_load,
	input wire [12:0] pc_load_value,
	input wire        global_irq_enable,
	input wire [7:0]  prescaler_edge_config_out,
	input wire [4:0]  first_io_direction_out,
	input wire [7:0]  second_io_direction_out
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// Any reset cause request
	wire any_req = por_req | brownout_req | watchdog_req | external_reset_pin_req;
	hold_release_a: assert property ($fell(core_hold) |-> pc_load && pc_load_value == 13'h0000)
		else $error("no zero pc load after release");
	dir_reset_a: assert property ($fell(core_hold) |=> first_io_direction_out == 5'h1F && second_io_direction_out == 8'hFF)
		else $error("directions not all inputs after release");
	presc_reset_a: assert property ($fell(core_hold) |=> prescaler_edge_config_out == 8'hFF)
		else $error("prescaler not all ones after release");
	gie_reset_a: assert property ($fell(core_hold) |=> !global_irq_enable)
		else $error("global enable set after release");
	read_upper_a: assert property (pready |-> prdata[31:8] == 24'h000000)
		else $error("upper read bits not zero");
	hold_rise_a: assert property ($rose(any_req) |-> ##[2:7] core_hold)
		else $error("core not held after reset request");
	hold_keep_a: assert property (core_hold && any_req |=> core_hold)
		else $error("hold released while cause present");
	pc_pulse_a: assert property (pc_load |=> !pc_load)
		else $error("pc load longer than one cycle");
	cover property ($fell(core_hold));
	cover property (pc_load && pc_load_value == 13'h0004);
	cover property (pc_load && pc_load_value != 13'h0000 && !core_hold);
endmodule
bind sri_sfr_init sri_chk sri_chk_inst (.clk(clk), .rst_n(rst_n), .pready(pready), .prdata(prdata),
	.por_req(por_req), .brownout_req(brownout_req), .watchdog_req(watchdog_req),
	.external_reset_pin_req(external_reset_pin_req), .core_hold(core_hold), .pc_load(pc_load),
	.pc_load_value(pc_load_value), .global_irq_enable(global_irq_enable),
	.prescaler_edge_config_out(prescaler_edge_config_out), .first_io_direction_out(first_io_direction_out),
	.second_io_direction_out(second_io_direction_out));

// file: tb/tb_sri_sfr_init.sv
`timescale 1ns/100ps
module tb_sri_sfr_init;
	logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, sleep_active, wake_periph_flag;
	logic        core_hold, pc_load, global_irq_enable, re, pf;
	logic [9:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [5:0]  rq;
	logic [7:0]  wake_int_flags, prescaler_edge_config_out, second_io_direction_out, fl;
	logic [4:0]  first_io_direction_out;
	logic [12:0] pc_current, pc_load_value, pc, pv;
	logic [7:0]  mdl [256];
	logic [7:0]  ix [19] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h0A, 8'h0B, 8'h0C,
		8'h1F, 8'h81, 8'h85, 8'h86, 8'h8C, 8'h8E, 8'h90, 8'h9F, 8'hA0};
	logic [7:0]  mk [19] = '{8'h00, 8'hFF, 8'hFF, 8'hE7, 8'hFF, 8'h1F, 8'hFF, 8'h1F, 8'hFF, 8'h01,
		8'h3F, 8'hFF, 8'h1F, 8'hFF, 8'h01, 8'h03, 8'hFF, 8'hEF, 8'hFF};
	int          bp [8] = '{0, 3, 3, 2, 1, 0, 5, 4};
	int          err_count, checked;

	sri_sfr_init sri_sfr_init_inst (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
		.prdata, .pslverr, .por_req(rq[0]), .brownout_req(rq[1]), .watchdog_req(rq[2]),
		.external_reset_pin_req(rq[3]), .wake_irq_req(rq[4]), .wake_watchdog_req(rq[5]), .sleep_active,
		.wake_int_flags, .wake_periph_flag, .pc_current, .core_hold, .pc_load, .pc_load_value,
		.global_irq_enable, .prescaler_edge_config_out, .first_io_direction_out, .second_io_direction_out);

	// Clock
	initial
	begin
		clk = 0;
		forever #2.5 clk = ~clk;
	end

	task test_done;
		$display("checks %0d, errors %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		checked++;
		if (s !== e)
		begin
			err_count++;
			$display("unexpected %s: expected %h, seen %h", nm, e, s);
		end
	endtask

	// Bounded wait for a pc_load (pl=1) or core_hold level
	task wt(input logic pl, input logic v);
		int n;
		n = 0;
		while ((pl ? pc_load : core_hold) !== v)
		begin
			n++;
			if (n > 40)
			begin
				err_count++;
				test_done;
			end
			@(posedge clk);
		end
	endtask

	// One APB transfer, held until pready
	task apb(input logic w, input logic [9:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h000000, d};
		@(posedge clk);
		penable <= 1;
		@(posedge clk);
		while (pready !== 1'b1)
		begin
			n++;
			if (n > 20)
			begin
				err_count++;
				test_done;
			end
			@(posedge clk);
		end
		rd = prdata;
		re = pslverr;
		psel <= 0;
		penable <= 0;
	endtask

	// Value after cause c, from the old value o of register a
	function automatic logic [7:0] nx(int c, logic [7:0] a, logic [7:0] o);
		logic w;
		w = c > 5;
		case (a)
		8'h02: return w ? pv[7:0] : 8'h00;
		8'h03:
			case (c)
			1: return {3'h0, o[4:0]};
			2: return {5'h02, o[2:0]};
			3: return {5'h01, o[2:0]};
			6: return {o[7:5], 2'b00, o[2:0]};
			7: return {o[7:5], 2'b10, o[2:0]};
			default: return {5'h03, o[2:0]};
			endcase
		8'h0A, 8'h1F, 8'h9F, 8'h8C: return w ? o : 8'h00;
		8'h0C: return w ? (o | {7'h00, c == 7 && pf}) : 8'h00;
		8'h0B: return w ? (c == 7 ? o | fl : o) : {7'h00, o[0]};
		8'h81, 8'h86: return w ? o : 8'hFF;
		8'h85: return w ? o : 8'h1F;
		8'h8E: return c == 5 ? 8'h00 : (c == 4 ? o & 8'h02 : o);
		8'h90: return o | 8'h07;
		default: return o;
		endcase
	endfunction

	// Read back every register except the cause state register, and the mirrored outputs
	task chkall;
		for (int i = 0; i < 19; i++)
		begin
			apb(0, {ix[i], 2'b00}, 8'h00);
			chk($sformatf("reg %h", ix[i]), rd, {24'h000000, mdl[ix[i]]});
			chk("read error", 32'(re), 32'h0);
		end
		chk("outputs", 32'({global_irq_enable, prescaler_edge_config_out, first_io_direction_out,
			second_io_direction_out}), 32'({mdl[8'h0B][7], mdl[8'h81], mdl[8'h85][4:0], mdl[8'h86]}));
	endtask

	// Random writes through the model masks
	task wrall;
		logic [7:0] v;
		for (int i = 0; i < 19; i++)
		begin
			v = 8'($urandom);
			apb(1, {ix[i], 2'b00}, v);
			mdl[ix[i]] = (v & mk[i]) | (mdl[ix[i]] & ~mk[i]);
		end
	endtask

	// Apply reset or wake cause c and update the model
	task trig(input int c);
		fl = 8'($urandom) & 8'h7F;
		pf = 1'($urandom);
		pc = 13'($urandom);
		pv = (c == 7 && mdl[8'h0B][7]) ? 13'h0004 : pc + 13'h0001;
		wake_int_flags <= fl;
		wake_periph_flag <= pf;
		pc_current <= pc;
		sleep_active <= (c == 2);
		rq <= 6'h01 << bp[c];
		if (c < 6)
		begin
			wt(0, 1);
			rq <= 6'h00;
			// Write while held must be refused
			apb(1, {8'hA0, 2'b00}, ~mdl[8'hA0]);
		end
		wt(1, 1);
		chk("pc load value", 32'(pc_load_value), 32'(c < 6 ? 13'h0000 : pv));
		rq <= 6'h00;
		sleep_active <= 0;
		repeat (8) @(posedge clk);
		for (int i = 0; i < 256; i++)
			mdl[i] = nx(c, 8'(i), mdl[i]);
		apb(0, {8'hA1, 2'b00}, 8'h00);
		chk("cause", 32'(rd[2:0]), 32'(c));
	endtask

	// Block reset for ten cycles, then reload the power-on model
	task hard_reset;
		rst_n <= 0;
		repeat (10) @(posedge clk);
		rst_n <= 1;
		foreach (mdl[i]) mdl[i] = 8'h00;
		mdl[8'h03] = 8'h18;
		mdl[8'h81] = 8'hFF;
		mdl[8'h85] = 8'h1F;
		mdl[8'h86] = 8'hFF;
		mdl[8'h90] = 8'h07;
		@(posedge clk);
		wt(0, 0);
		chk("release pc load", 32'({pc_load, pc_load_value}), 32'h0000_2000);
	endtask

	// Main sequence
	initial
	begin
		psel = 0;
		penable = 0;
		pwrite = 0;
		paddr = 0;
		pwdata = 0;
		rq = 0;
		sleep_active = 0;
		wake_int_flags = 0;
		wake_periph_flag = 0;
		pc_current = 0;
		void'($urandom(4));
		hard_reset;
		chkall;
		apb(1, 10'h040, 8'hFF);
		chk("unmapped", {re, rd[30:0]}, 32'h80000000);
		apb(0, 10'h005, 8'h00);
		chk("misaligned", 32'(re), 32'h1);
		for (int r = 0; r < 3; r++)
			for (int c = 1; c < 8; c++)
			begin
				wrall;
				chkall;
				trig(c);
				chkall;
			end
		// Mid-run block reset
		hard_reset;
		chkall;
		test_done;
	end
endmodule
